//--- rtl/shpc_regs.svh
// constants for the serial host pin control block
`ifndef SHPC_REGS_SVH
`define SHPC_REGS_SVH
`define SHPC_WORD_BITS       8
`define SHPC_CNT_BITS        4
`define SHPC_DIV_HALF        4'h4
`define SHPC_MODE_SPI_MASTER 2'h0
`define SHPC_MODE_SPI_SLAVE  2'h1
`define SHPC_MODE_I2C_SLAVE  2'h2
`define SHPC_MODE_I2C_MASTER 2'h3
`define SHPC_GP_DISC         2'h0
`define SHPC_GP_IN           2'h1
`define SHPC_GP_OUT          2'h2
`endif

//--- rtl/shpc_pkg.sv
// types for the serial host pin control block
package shpc_pkg;
   typedef logic [1:0] shpc_mode_type;
   typedef logic [1:0] shpc_gp_type;
   typedef enum logic [1:0] {shpc_idle, shpc_run, shpc_wait} shpc_state_type;
endpackage

//--- rtl/shpc_sync_if.sv
// interface carrying synchronised pin levels
`timescale 1ns/1ps
`default_nettype none
interface shpc_sync_if;
   logic sck;
   logic mosi;
   logic ss_n;
   logic host_request_n_n;
   logic addr0;
   logic addr2;
   modport src (output sck, mosi, ss_n, host_request_n_n, addr0, addr2);
   modport dst (input sck, mosi, ss_n, host_request_n_n, addr0, addr2);
endinterface
`default_nettype wire

//--- rtl/shpc_sync.sv
// two-flop synchronisers for all pin inputs except miso, which shpc_top synchronises itself
`timescale 1ns/1ps
`default_nettype none
module shpc_sync
(
   input  wire logic  core_clk,
   input  wire logic  srst,
   input  wire logic  sck_in,
   input  wire logic  mosi_in,
   input  wire logic  ss_n_in,
   input  wire logic  host_request_n_n_in,
   input  wire logic  addr0_in,
   input  wire logic  addr2_in,
   shpc_sync_if.src   so
);
   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meta_reg <= 6'h3F;
         sync_reg <= 6'h3F;
      end
      else
      begin
         meta_reg <= {sck_in, mosi_in, ss_n_in, host_request_n_n_in, addr0_in, addr2_in};
         sync_reg <= meta_reg;
      end
   end
   assign so.sck    = sync_reg[5];
   assign so.mosi   = sync_reg[4];
   assign so.ss_n   = sync_reg[3];
   assign so.host_request_n_n = sync_reg[2];
   assign so.addr0  = sync_reg[1];
   assign so.addr2  = sync_reg[0];
endmodule
`default_nettype wire

//--- rtl/shpc_top.sv
// serial host pin control: spi pins, address straps, host request
`timescale 1ns/1ps
`default_nettype none
`include "shpc_regs.svh"
module shpc_top
(
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire shpc_pkg::shpc_mode_type mode,
   input  wire logic               cpol,
   input  wire logic               cpha,
   input  wire logic               host_request_n_handshake,
   input  wire shpc_pkg::shpc_gp_type gp_dir,
   input  wire logic               gp_out_val,
   input  wire logic [7:0]         tx_word,
   input  wire logic               tx_ready,
   input  wire logic               bus_err_clr,
   input  wire logic               sck_in,
   input  wire logic               mosi_in,
   input  wire logic               ss_n_in,
   input  wire logic               host_request_n_n_in,
   input  wire logic               addr0_in,
   input  wire logic               addr2_in,
   input  wire logic               miso_in,
   output logic                    sck_out,
   output logic                    sck_oe,
   output logic                    mosi_out,
   output logic                    mosi_oe,
   output logic                    miso_out,
   output logic                    miso_oe,
   output logic                    host_request_n_n_out,
   output logic                    host_request_n_n_oe,
   output logic                    addr0_oe,
   output logic [1:0]              slave_addr_bits,
   output logic                    gp_in_val,
   output logic                    bus_error,
   output logic [7:0]              rx_word,
   output logic                    rx_valid
);
   import shpc_pkg::*;

   shpc_sync_if s ();
   shpc_sync u_sync
   (
      .core_clk  (core_clk),
      .srst      (srst),
      .sck_in    (sck_in),
      .mosi_in   (mosi_in),
      .ss_n_in   (ss_n_in),
      .host_request_n_n_in (host_request_n_n_in),
      .addr0_in  (addr0_in),
      .addr2_in  (addr2_in),
      .so        (s)
   );

   logic            miso_m1_reg;
   logic            miso_m2_reg;
   logic            sck_prev_reg;
   logic            host_request_n_prev_reg;
   logic            host_request_n_armed_reg;
   shpc_state_type  state_reg;
   logic [3:0]      div_reg;
   logic [3:0]      bit_reg;
   logic [7:0]      sh_reg;
   logic [7:0]      rx_reg;
   logic            msck_reg;

   wire is_master   = (mode == `SHPC_MODE_SPI_MASTER);
   wire is_slave    = (mode == `SHPC_MODE_SPI_SLAVE);
   wire is_i2c_slv  = (mode == `SHPC_MODE_I2C_SLAVE);
   wire slv_sel     = is_slave && !s.ss_n;
   wire sck_rise    = s.sck && !sck_prev_reg;
   wire sck_fall    = !s.sck && sck_prev_reg;
   wire lead_edge   = cpol ? sck_fall : sck_rise;
   wire trail_edge  = cpol ? sck_rise : sck_fall;
   wire samp_edge   = cpha ? trail_edge : lead_edge;
   wire shift_edge  = cpha ? lead_edge : trail_edge;
   wire first_clk   = slv_sel && lead_edge && (bit_reg == 4'h0);
   wire last_bit    = (bit_reg == 4'h7);
   wire div_tick    = (div_reg == `SHPC_DIV_HALF - 4'h1);
   wire host_request_n_fell   = host_request_n_prev_reg && !s.host_request_n_n;
   // start only on a fresh request
   wire m_start     = is_master && host_request_n_handshake && host_request_n_armed_reg && !s.host_request_n_n && tx_ready;
   wire m_lead      = div_tick && (msck_reg == cpol);
   wire m_trail     = div_tick && (msck_reg != cpol);

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         miso_m1_reg    <= 1'h0;
         miso_m2_reg    <= 1'h0;
         sck_prev_reg   <= 1'h1;
         host_request_n_prev_reg  <= 1'h1;
         host_request_n_armed_reg <= 1'h0;
      end
      else
      begin
         miso_m1_reg    <= miso_in;
         miso_m2_reg    <= miso_m1_reg;
         sck_prev_reg   <= s.sck;
         host_request_n_prev_reg  <= s.host_request_n_n;
         if (host_request_n_fell)
            host_request_n_armed_reg <= 1'h1;
         else if (m_start)
            host_request_n_armed_reg <= 1'h0;
      end
   end

   // master clock divider and master/slave shift engine
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg <= shpc_idle;
         div_reg   <= 4'h0;
         bit_reg   <= 4'h0;
         sh_reg    <= 8'h00;
         rx_reg    <= 8'h00;
         msck_reg  <= 1'h0;
         rx_valid  <= 1'h0;
      end
      else
      begin
         rx_valid <= 1'h0;
         case (state_reg)
            shpc_idle:
            begin
               msck_reg <= cpol;
               div_reg  <= 4'h0;
               bit_reg  <= 4'h0;
               if (m_start)
               begin
                  sh_reg    <= tx_word;
                  state_reg <= shpc_run;
               end
               else if (slv_sel && tx_ready)
               begin
                  sh_reg    <= tx_word;
                  state_reg <= shpc_wait;
               end
            end
            shpc_run:
            begin
               div_reg <= div_tick ? 4'h0 : div_reg + 4'h1;
               if (div_tick)
                  msck_reg <= !msck_reg;
               if ((m_lead && !cpha) || (m_trail && cpha))
                  rx_reg <= {rx_reg[6:0], miso_m2_reg};
               if ((m_trail && !cpha) || (m_lead && cpha && bit_reg != 4'h0))
                  sh_reg <= {sh_reg[6:0], 1'h0};
               if (m_trail)
               begin
                  bit_reg <= bit_reg + 4'h1;
                  if (last_bit)
                  begin
                     rx_valid  <= 1'h1;
                     state_reg <= shpc_idle;
                  end
               end
            end
            shpc_wait:
            begin
               if (!slv_sel)
                  state_reg <= shpc_idle;
               else
               begin
                  if (samp_edge)
                     rx_reg <= {rx_reg[6:0], s.mosi};
                  if (shift_edge && !(cpha && bit_reg == 4'h0))
                     sh_reg <= {sh_reg[6:0], 1'h0};
                  if (trail_edge)
                  begin
                     bit_reg <= bit_reg + 4'h1;
                     if (last_bit)
                     begin
                        rx_valid  <= 1'h1;
                        state_reg <= shpc_idle;
                     end
                  end
               end
            end
            default:
               state_reg <= shpc_idle;
         endcase
      end
   end

   // pin drivers
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sck_out         <= 1'h0;
         sck_oe          <= 1'h0;
         mosi_out        <= 1'h0;
         mosi_oe         <= 1'h0;
         miso_out        <= 1'h0;
         miso_oe         <= 1'h0;
         host_request_n_n_out      <= 1'h1;
         host_request_n_n_oe       <= 1'h0;
         addr0_oe        <= 1'h0;
         slave_addr_bits <= 2'h0;
         gp_in_val       <= 1'h0;
         bus_error       <= 1'h0;
         rx_word         <= 8'h00;
      end
      else
      begin
         sck_out  <= (state_reg == shpc_run) ? msck_reg : cpol;
         sck_oe   <= is_master;
         mosi_out <= sh_reg[7];
         mosi_oe  <= is_master;
         miso_out <= sh_reg[7];
         miso_oe  <= slv_sel;
         addr0_oe <= 1'h0;
         slave_addr_bits <= is_i2c_slv ? {s.addr2, s.addr0} : 2'h0;
         if (is_master && !s.ss_n)
            bus_error <= 1'h1;
         else if (bus_err_clr)
            bus_error <= 1'h0;
         if (rx_valid)
            rx_word <= rx_reg;
         if (host_request_n_handshake)
         begin
            host_request_n_n_oe <= is_slave;
            if (first_clk || !is_slave)
               host_request_n_n_out <= 1'h1;
            else if (state_reg == shpc_idle && tx_ready)
               host_request_n_n_out <= 1'h0;
            gp_in_val <= 1'h0;
         end
         else
         begin
            host_request_n_n_oe  <= (gp_dir == `SHPC_GP_OUT);
            host_request_n_n_out <= gp_out_val;
            gp_in_val  <= (gp_dir == `SHPC_GP_IN) ? s.host_request_n_n : 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/shpc_top_sva.sv
// assertions on the serial host pin control ports
`timescale 1ns/1ps
`default_nettype none
`include "shpc_regs.svh"
module shpc_top_sva
(
   input wire logic                    core_clk,
   input wire logic                    srst,
   input wire shpc_pkg::shpc_mode_type mode,
   input wire logic                    ss_n_in,
   input wire logic                    host_request_n_handshake,
   input wire shpc_pkg::shpc_gp_type   gp_dir,
   input wire logic                    addr0_in,
   input wire logic                    addr2_in,
   input wire logic                    mosi_oe,
   input wire logic                    miso_oe,
   input wire logic                    host_request_n_n_oe,
   input wire logic                    host_request_n_n_out,
   input wire logic [1:0]              slave_addr_bits,
   input wire logic                    bus_error
);
   import shpc_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   chk_reset_pins_quiet: assert property (disable iff (1'b0) srst |=> !mosi_oe && !miso_oe && !host_request_n_n_oe && host_request_n_n_out)
      else $error("pins driven after reset");
   chk_master_mosi_out: assert property ((mode == `SHPC_MODE_SPI_MASTER)[*3] |-> mosi_oe)
      else $error("master not driving mosi");
   chk_slave_mosi_in: assert property ((mode == `SHPC_MODE_SPI_SLAVE)[*3] |-> !mosi_oe)
      else $error("slave driving mosi");
   chk_select_bus_error: assert property ((mode == `SHPC_MODE_SPI_MASTER && !ss_n_in)[*5] |-> bus_error)
      else $error("bus error not flagged");
   chk_miso_released: assert property (ss_n_in[*4] |-> !miso_oe)
      else $error("miso driven while deselected");
   chk_slave_request_out: assert property ((mode == `SHPC_MODE_SPI_SLAVE && host_request_n_handshake)[*3] |-> host_request_n_n_oe)
      else $error("slave request not driven");
   chk_master_request_in: assert property ((mode == `SHPC_MODE_SPI_MASTER && host_request_n_handshake)[*3] |-> !host_request_n_n_oe)
      else $error("master drives request pin");
   chk_gp_disconnected: assert property ((!host_request_n_handshake && gp_dir == `SHPC_GP_DISC)[*3] |-> !host_request_n_n_oe)
      else $error("disconnected line driven");
   chk_slave_addr_bits: assert property ((mode == `SHPC_MODE_I2C_SLAVE && $stable({addr2_in, addr0_in}))[*5]
      |-> slave_addr_bits == {addr2_in, addr0_in})
      else $error("address bits wrong");
   chk_master_addr_off: assert property ((mode == `SHPC_MODE_I2C_MASTER)[*2] |-> slave_addr_bits == 2'h0)
      else $error("address used as master");
endmodule
bind shpc_top shpc_top_sva chk_u (.*);
`default_nettype wire

//--- tb/shpc_partner.sv
// partner model: spi slave raising host request, answering on miso
`timescale 1ns/1ps
`default_nettype none
module shpc_partner
(
   input  wire logic sck,
   input  wire logic req,
   output logic      host_request_n_n,
   output logic      miso
);
   assign host_request_n_n = ~req;
   // data changes on every sck edge
   initial miso = 1'b0;
   always @(sck)
      miso = ~miso;
endmodule
`default_nettype wire

//--- tb/shpc_top_tb.sv
// testbench for the serial host pin control block
`timescale 1ns/1ps
`default_nettype none
`include "shpc_regs.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module shpc_top_tb;
   import shpc_pkg::*;
   // bench keeps ss high in master role except while t_buserr drives it low
   logic core_clk = 1'b0, srst = 1'b1, cpol = 1'b0, cpha = 1'b0, host_request_n_handshake = 1'b1, gp_out_val = 1'b0;
   logic tx_ready = 1'b0, bus_err_clr = 1'b0, sck_in = 1'b0, mosi_in = 1'b0, ss_n_in = 1'b1;
   logic addr0_in = 1'b0, addr2_in = 1'b0, p_req = 1'b0;
   logic [7:0] tx_word = 8'hA5;
   shpc_mode_type mode = `SHPC_MODE_SPI_MASTER;
   shpc_gp_type gp_dir = `SHPC_GP_DISC;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, host_request_n_n_out, host_request_n_n_oe, addr0_oe, gp_in_val;
   logic bus_error, rx_valid;
   logic [1:0] slave_addr_bits;
   logic [7:0] rx_word;
   wire logic host_request_n_n_in, miso_in, p_host_request_n_n;
   int err_count = 0, cmp_count = 0, cyc = 0, rxn = 0;
   assign host_request_n_n_in = host_request_n_n_oe ? host_request_n_n_out : p_host_request_n_n;
   shpc_top dut_u (.*);
   shpc_partner p_u (.sck(sck_out), .req(p_req), .host_request_n_n(p_host_request_n_n), .miso(miso_in));
   initial
      forever
         #5 core_clk = ~core_clk;
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic sck_edges(input int n);
      repeat (n)
      begin
         w(8);
         sck_in <= ~sck_in;
      end
   endtask
   task automatic t_reset;
      @(negedge core_clk);
      `CHK("mosi_oe", 1'b0, mosi_oe)
      `CHK("host_request_n_n_oe", 1'b0, host_request_n_n_oe)
      `CHK("addr0_oe", 1'b0, addr0_oe)
   endtask
   task automatic t_master;
      w(1);
      tx_ready <= 1'b1;
      p_req <= 1'b1;
      w(200);
      `CHK("master words", 1, rxn)
      `CHK("sck_oe", 1'b1, sck_oe)
      w(200);
      `CHK("held request words", 1, rxn)
      p_req <= 1'b0;
      w(10);
      p_req <= 1'b1;
      w(200);
      `CHK("fresh request words", 2, rxn)
      p_req <= 1'b0;
   endtask
   task automatic t_buserr;
      ss_n_in <= 1'b0;
      w(6);
      ss_n_in <= 1'b1;
      w(4);
      `CHK("bus_error set", 1'b1, bus_error)
      bus_err_clr <= 1'b1;
      w(1);
      bus_err_clr <= 1'b0;
      w(3);
      `CHK("bus_error clear", 1'b0, bus_error)
   endtask
   task automatic t_slave;
      mode <= `SHPC_MODE_SPI_SLAVE;
      tx_ready <= 1'b1;
      mosi_in <= 1'b1;
      w(8);
      `CHK("request ready", 1'b0, host_request_n_n_out)
      `CHK("miso_oe idle", 1'b0, miso_oe)
      sck_edges(16);
      w(6);
      `CHK("deselected words", 2, rxn)
      `CHK("request kept", 1'b0, host_request_n_n_out)
      ss_n_in <= 1'b0;
      sck_edges(1);
      w(7);
      `CHK("request released", 1'b1, host_request_n_n_out)
      sck_edges(15);
      w(8);
      ss_n_in <= 1'b1;
      `CHK("selected words", 3, rxn)
      `CHK("slave rx word", 8'hFF, rx_word)
      // second phase: clock idles high, sample on trailing edge
      cpol <= 1'b1;
      cpha <= 1'b1;
      sck_in <= 1'b1;
      mosi_in <= 1'b0;
      w(8);
      ss_n_in <= 1'b0;
      w(8);
      sck_edges(16);
      w(8);
      ss_n_in <= 1'b1;
      `CHK("phase one words", 4, rxn)
      `CHK("phase one rx word", 8'h00, rx_word)
      w(4);
      cpol <= 1'b0;
      cpha <= 1'b0;
      sck_in <= 1'b0;
      w(4);
   endtask
   task automatic t_i2c;
      mode <= `SHPC_MODE_I2C_SLAVE;
      addr0_in <= 1'b1;
      w(6);
      `CHK("addr bits lo", 2'h1, slave_addr_bits)
      addr0_in <= 1'b0;
      addr2_in <= 1'b1;
      w(6);
      `CHK("addr bits hi", 2'h2, slave_addr_bits)
      mode <= `SHPC_MODE_I2C_MASTER;
      w(6);
      `CHK("addr bits master", 2'h0, slave_addr_bits)
   endtask
   task automatic t_gp;
      host_request_n_handshake <= 1'b0;
      gp_dir <= `SHPC_GP_OUT;
      gp_out_val <= 1'b1;
      w(4);
      `CHK("gp out high", 2'h3, {host_request_n_n_oe, host_request_n_n_out})
      gp_out_val <= 1'b0;
      w(4);
      `CHK("gp out low", 2'h2, {host_request_n_n_oe, host_request_n_n_out})
      gp_dir <= `SHPC_GP_IN;
      p_req <= 1'b1;
      w(6);
      `CHK("gp in low", 2'h0, {host_request_n_n_oe, gp_in_val})
      p_req <= 1'b0;
      w(6);
      `CHK("gp in high", 1'b1, gp_in_val)
      gp_dir <= `SHPC_GP_DISC;
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (rx_valid === 1'b1)
         rxn++;
      if (cyc == 6000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      w(9);
      t_reset();
      w(1);
      srst <= 1'b0;
      t_master();
      t_buserr();
      t_slave();
      t_i2c();
      t_gp();
      w(4);
      summarize();
   end
endmodule
`default_nettype wire
